// ---- pkg/cmf_if.sv ----
// Purpose: Pins between the bridge channel logic and the external peripheral
// Assumes: One clock domain on both sides
// Notes:   Flush/wake pin is channel A's; channel B pins shown as levels
`timescale 1ns/100ps
`default_nettype none
interface cmf_if;
	logic flush_wake_n;      // Low pulse from peripheral
	logic b_data_oe;         // Channel B data lines driven
	logic b_pullup_en;       // Channel B data pull-ups on
	logic b_tx_space_flag_n; // Channel B space flag, active low
	logic b_rx_avail_flag_n; // Channel B data-available flag, active low

	// Documented device end
	modport dev (
		input  flush_wake_n,
		output b_data_oe,
		output b_pullup_en,
		output b_tx_space_flag_n,
		output b_rx_avail_flag_n
	);
	// Peripheral end
	modport per (
		output flush_wake_n,
		input  b_data_oe,
		input  b_pullup_en,
		input  b_tx_space_flag_n,
		input  b_rx_avail_flag_n
	);
endinterface
`default_nettype wire

// ---- pkg/cmf_pkg.sv ----
// Purpose: Shared constants and types for channel mode selection and flush/wake
// Assumes: 100 MHz system clock on both ends
// Notes:   Mode codes are internal; bit-mode command values are the host's
package cmf_pkg;
	// Clock period
	localparam int CLK_PERIOD_NS   = 10;
	// Flush pulse that the peripheral drives, least time, rounded up
	localparam int FLUSH_PULSE_NS  = 250;
	localparam int FLUSH_CYC       = (FLUSH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Wake pulse that the peripheral drives
	localparam int WAKE_PULSE_MS   = 20;
	localparam int WAKE_CYC        = (WAKE_PULSE_MS * 1000000) / CLK_PERIOD_NS;
	// Low time at which the device accepts a wake request
	localparam int WAKE_DETECT_MS  = 10;
	localparam int WAKE_DETECT_CYC = (WAKE_DETECT_MS * 1000000) / CLK_PERIOD_NS;
	// Pulse length counter width
	localparam int CNT_W           = 21;

	// Channel operating modes
	typedef enum logic [3:0] {
		CMF_UART       = 4'h0,
		CMF_ASYNC_FIFO = 4'h1,
		CMF_SYNC_FIFO  = 4'h2,
		CMF_CPU_FIFO   = 4'h3,
		CMF_FAST_SER   = 4'h4,
		CMF_BB_ASYNC   = 4'h5,
		CMF_BB_SYNC    = 4'h6,
		CMF_SER_ENGINE = 4'h7,
		CMF_HOST_BUS   = 4'h8
	} cmf_mode_t;

	// Configuration memory mode codes, two bits per channel
	localparam logic [1:0] CFG_UART       = 2'h0;
	localparam logic [1:0] CFG_ASYNC_FIFO = 2'h1;
	localparam logic [1:0] CFG_CPU_FIFO   = 2'h2;
	localparam logic [1:0] CFG_FAST_SER   = 2'h3;

	// Bit-mode command values
	localparam logic [7:0] BM_RESTORE    = 8'h00;
	localparam logic [7:0] BM_BB_ASYNC   = 8'h01;
	localparam logic [7:0] BM_SER_ENGINE = 8'h02;
	localparam logic [7:0] BM_BB_SYNC    = 8'h04;
	localparam logic [7:0] BM_HOST_BUS   = 8'h08;
	localparam logic [7:0] BM_SYNC_FIFO  = 8'h40;

	// Register byte addresses
	localparam logic [3:0] REG_CMD    = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_CTRL   = 4'h8;
	localparam logic [3:0] REG_COUNT  = 4'hC;

	// Field positions
	localparam int CMD_CH_BIT     = 8;
	localparam int ST_MODE_B_LSB  = 4;
	localparam int ST_B_AVAIL     = 8;
	localparam int ST_REJECT      = 9;
	localparam int ST_LAST_WAKE   = 10;
	localparam int ST_LOADED      = 11;
	localparam int ST_B_USED      = 12;
	localparam int CTRL_PULLDOWN  = 0;
	localparam int CNT_WAKE_LSB   = 16;

	// Reset values
	localparam logic [15:0] CNT_RESET  = 16'h0000;
	localparam logic        CTRL_RESET = 1'b0;
endpackage

// ---- rtl/cmf_device.sv ----
// Purpose: Per-channel mode selection and flush/wake pin handling
// Assumes: Classic Wishbone slave, 32-bit data, one clock
// Notes:   Flush/wake pin belongs to channel A
// Functional notes
// - Flush/wake works only in FIFO or bit-bang
// - Flush sends buffered data as short packet
// - Peripheral flushes only after it stops writing
// - Falling edge flags the transfer to host
// - Wake needs a 20ms low pulse
// - Flush needs a 250ns low pulse
// - Pull-down enabled blocks wake from suspend
// - Both channels reset to asynchronous serial
// - Configuration memory picks mode after reset
// - Bit-mode command selects bit-bang or engine
// - Value 0x40 selects synchronous FIFO
// - Synchronous FIFO needs asynchronous FIFO first
// - Synchronous FIFO takes channel B memory
// - Unused channel B pins keep defaults
// - Software may set channel B pins inputs
// - Each mode has its allowed source
// - Value 1 selects asynchronous bit-bang
// - Value 4 selects synchronous bit-bang
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module cmf_device #(
	parameter int WAKE_DETECT = cmf_pkg::WAKE_DETECT_CYC // Low cycles taken as wake
) (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Configuration memory words, valid after reset
	input  wire logic [1:0]  cfg_mode_a_i,
	input  wire logic [1:0]  cfg_mode_b_i,
	// USB core side
	input  wire logic        suspend_i,
	input  wire logic        b_activity_i,
	input  wire logic        b_tx_space_n_i,
	input  wire logic        b_rx_avail_n_i,
	input  wire logic        b_data_oe_i,
	output logic             send_now_o,
	output logic             wake_o,
	output logic             b_avail_o,
	output logic [3:0]       mode_a_o,
	output logic [3:0]       mode_b_o,
	// Peripheral side
	cmf_if.dev               pins
);
	// Loader states, Gray along the path
	typedef enum logic [1:0] {
		LD_RESET = 2'b00,
		LD_READ  = 2'b01,
		LD_RUN   = 2'b11
	} cmf_ld_t;

	// Map a configuration memory code to a mode
	function automatic cmf_pkg::cmf_mode_t cfg_to_mode(input logic [1:0] code);
		case (code)
			cmf_pkg::CFG_ASYNC_FIFO: cfg_to_mode = cmf_pkg::CMF_ASYNC_FIFO;
			cmf_pkg::CFG_CPU_FIFO:   cfg_to_mode = cmf_pkg::CMF_CPU_FIFO;
			cmf_pkg::CFG_FAST_SER:   cfg_to_mode = cmf_pkg::CMF_FAST_SER;
			default:                 cfg_to_mode = cmf_pkg::CMF_UART;
		endcase
	endfunction

	cmf_ld_t               ld_q, ld_d;           // Loader state
	cmf_pkg::cmf_mode_t    mode_q [2], mode_d [2]; // Live channel modes
	cmf_pkg::cmf_mode_t    cfgm_q [2], cfgm_d [2]; // Modes from memory
	logic                  reject_q, reject_d;   // Last command refused
	logic                  pulldn_q, pulldn_d;   // Pull-down option
	logic                  b_used_q, b_used_d;   // Channel B carried data
	logic                  last_wake_q, last_wake_d; // Last pulse was wake
	logic                  woke_q, woke_d;       // Wake given this pulse
	logic [15:0]           nflush_q, nflush_d;   // Flush events
	logic [15:0]           nwake_q, nwake_d;     // Wake events
	logic                  ack_q;                // Answer given last cycle
	logic [31:0]           rdat_q, rdat_d;       // Read data
	logic                  boe_q, bpu_q, btx_q, brx_q; // Channel B pin regs
	logic                  boe_d, bpu_d, btx_d, brx_d;
	logic                  fall, rise;           // Pin edges
	logic [cmf_pkg::CNT_W-1:0] low_cnt;          // Current low time
	logic                  req, wr_cmd, pin_en, flush_ev, wake_ev, sync_on;
	logic [7:0]            bm;                   // Command value
	logic                  ch;                   // Command channel

	// Pin synchroniser and pulse timer
	cmf_pulse_meter u_meter (
		.clk_i     (clk_i),
		.resetn_i  (resetn_i),
		.pin_n_i   (pins.flush_wake_n),
		.fall_o    (fall),
		.rise_o    (rise),
		.low_cnt_o (low_cnt)
	);

	// Bus decode
	assign req    = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr_cmd = req & wb_we_i & (wb_adr_i == cmf_pkg::REG_CMD) & wb_sel_i[0] & wb_sel_i[1];
	assign bm     = wb_dat_i[7:0];
	assign ch     = wb_dat_i[cmf_pkg::CMD_CH_BIT];
	assign sync_on = (mode_q[0] == cmf_pkg::CMF_SYNC_FIFO);

	// Pin function allowed in FIFO and bit-bang modes only
	always_comb begin
		case (mode_q[0])
			cmf_pkg::CMF_ASYNC_FIFO, cmf_pkg::CMF_SYNC_FIFO, cmf_pkg::CMF_CPU_FIFO,
			cmf_pkg::CMF_BB_ASYNC, cmf_pkg::CMF_BB_SYNC: pin_en = 1'b1;
			default: pin_en = 1'b0;
		endcase
	end

	// Flush at the falling edge, wake once the low time is long enough
	assign flush_ev = fall & pin_en & ~suspend_i;
	assign wake_ev  = pin_en & suspend_i & ~pulldn_q & ~woke_q
	                  & (low_cnt == WAKE_DETECT[cmf_pkg::CNT_W-1:0]);

	// Loader, modes and command handling
	always_comb begin
		ld_d      = ld_q;
		mode_d    = mode_q;
		cfgm_d    = cfgm_q;
		reject_d  = reject_q;
		case (ld_q)
			LD_RESET: ld_d = LD_READ;
			LD_READ: begin
				// Memory decides each channel's mode
				cfgm_d[0] = cfg_to_mode(cfg_mode_a_i);
				cfgm_d[1] = cfg_to_mode(cfg_mode_b_i);
				mode_d[0] = cfg_to_mode(cfg_mode_a_i);
				mode_d[1] = cfg_to_mode(cfg_mode_b_i);
				ld_d      = LD_RUN;
			end
			LD_RUN: begin
				if (wr_cmd) begin
					reject_d = 1'b0;
					if (ch && sync_on) begin
						// Channel B gone while A holds its memory
						reject_d = 1'b1;
					end else begin
						case (bm)
							cmf_pkg::BM_RESTORE:    mode_d[ch] = cfgm_q[ch];
							cmf_pkg::BM_BB_ASYNC:   mode_d[ch] = cmf_pkg::CMF_BB_ASYNC;
							cmf_pkg::BM_BB_SYNC:    mode_d[ch] = cmf_pkg::CMF_BB_SYNC;
							cmf_pkg::BM_SER_ENGINE: mode_d[ch] = cmf_pkg::CMF_SER_ENGINE;
							cmf_pkg::BM_HOST_BUS:   mode_d[ch] = cmf_pkg::CMF_HOST_BUS;
							cmf_pkg::BM_SYNC_FIFO: begin
								// Only channel A, both in asynchronous FIFO
								if (!ch && cfgm_q[0] == cmf_pkg::CMF_ASYNC_FIFO
								    && cfgm_q[1] == cmf_pkg::CMF_ASYNC_FIFO
								    && mode_q[0] == cmf_pkg::CMF_ASYNC_FIFO) begin
									mode_d[0] = cmf_pkg::CMF_SYNC_FIFO;
								end else begin
									reject_d = 1'b1;
								end
							end
							default: reject_d = 1'b1;
						endcase
					end
				end
			end
			default: ld_d = LD_RESET;
		endcase
	end

	// Pulse bookkeeping, control bit and counters
	always_comb begin
		pulldn_d    = pulldn_q;
		b_used_d    = b_used_q | (b_activity_i & ~sync_on);
		woke_d      = woke_q;
		last_wake_d = last_wake_q;
		nflush_d    = nflush_q;
		nwake_d     = nwake_q;
		if (fall) begin
			woke_d = 1'b0;
		end
		if (flush_ev) begin
			nflush_d    = nflush_q + 16'h0001;
			last_wake_d = 1'b0;
		end
		if (wake_ev) begin
			woke_d      = 1'b1;
			last_wake_d = 1'b1;
			nwake_d     = nwake_q + 16'h0001;
		end
		if (req && wb_we_i && wb_adr_i == cmf_pkg::REG_CTRL && wb_sel_i[0]) begin
			pulldn_d = wb_dat_i[cmf_pkg::CTRL_PULLDOWN];
		end
		if (req && wb_we_i && wb_adr_i == cmf_pkg::REG_COUNT) begin
			// Any write clears both counts; a same-cycle event still counts
			nflush_d = flush_ev ? 16'h0001 : cmf_pkg::CNT_RESET;
			nwake_d  = wake_ev ? 16'h0001 : cmf_pkg::CNT_RESET;
		end
	end

	// Channel B pins: defaults unless used, held while A is synchronous
	always_comb begin
		boe_d = boe_q;
		bpu_d = bpu_q;
		btx_d = btx_q;
		brx_d = brx_q;
		if (!b_used_q) begin
			// Tri-stated, pulled up, space flag asserted, no data
			boe_d = 1'b0;
			bpu_d = 1'b1;
			btx_d = 1'b0;
			brx_d = 1'b1;
		end else if (!sync_on) begin
			boe_d = b_data_oe_i;
			bpu_d = ~b_data_oe_i;
			btx_d = b_tx_space_n_i;
			brx_d = b_rx_avail_n_i;
		end
	end

	// Read data mux
	always_comb begin
		rdat_d = 32'h0000_0000;
		case (wb_adr_i)
			cmf_pkg::REG_STATUS: begin
				rdat_d[3:0]                                  = mode_q[0];
				rdat_d[cmf_pkg::ST_MODE_B_LSB +: 4]          = mode_q[1];
				rdat_d[cmf_pkg::ST_B_AVAIL]                  = ~sync_on;
				rdat_d[cmf_pkg::ST_REJECT]                   = reject_q;
				rdat_d[cmf_pkg::ST_LAST_WAKE]                = last_wake_q;
				rdat_d[cmf_pkg::ST_LOADED]                   = (ld_q == LD_RUN);
				rdat_d[cmf_pkg::ST_B_USED]                   = b_used_q;
			end
			cmf_pkg::REG_CTRL:  rdat_d[cmf_pkg::CTRL_PULLDOWN] = pulldn_q;
			cmf_pkg::REG_COUNT: rdat_d = {nwake_q, nflush_q};
			default:            rdat_d = 32'h0000_0000;
		endcase
	end

	// All state registers; modes reset to serial
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ld_q        <= LD_RESET;
			mode_q[0]   <= cmf_pkg::CMF_UART;
			mode_q[1]   <= cmf_pkg::CMF_UART;
			cfgm_q[0]   <= cmf_pkg::CMF_UART;
			cfgm_q[1]   <= cmf_pkg::CMF_UART;
			reject_q    <= 1'b0;
			pulldn_q    <= cmf_pkg::CTRL_RESET;
			b_used_q    <= 1'b0;
			woke_q      <= 1'b0;
			last_wake_q <= 1'b0;
			nflush_q    <= cmf_pkg::CNT_RESET;
			nwake_q     <= cmf_pkg::CNT_RESET;
			ack_q       <= 1'b0;
			rdat_q      <= 32'h0000_0000;
			boe_q       <= 1'b0;
			bpu_q       <= 1'b1;
			btx_q       <= 1'b0;
			brx_q       <= 1'b1;
			send_now_o  <= 1'b0;
			wake_o      <= 1'b0;
		end else begin
			ld_q        <= ld_d;
			mode_q      <= mode_d;
			cfgm_q      <= cfgm_d;
			reject_q    <= reject_d;
			pulldn_q    <= pulldn_d;
			b_used_q    <= b_used_d;
			woke_q      <= woke_d;
			last_wake_q <= last_wake_d;
			nflush_q    <= nflush_d;
			nwake_q     <= nwake_d;
			ack_q       <= req;
			rdat_q      <= rdat_d;
			boe_q       <= boe_d;
			bpu_q       <= bpu_d;
			btx_q       <= btx_d;
			brx_q       <= brx_d;
			send_now_o  <= flush_ev; // Short packet out now
			wake_o      <= wake_ev;
		end
	end

	// Outputs
	assign wb_ack_o               = ack_q;
	assign wb_dat_o               = rdat_q;
	assign b_avail_o              = ~sync_on;
	assign mode_a_o               = mode_q[0];
	assign mode_b_o               = mode_q[1];
	assign pins.b_data_oe         = boe_q;
	assign pins.b_pullup_en       = bpu_q;
	assign pins.b_tx_space_flag_n = btx_q;
	assign pins.b_rx_avail_flag_n = brx_q;
endmodule
`default_nettype wire

// ---- rtl/cmf_peripheral.sv ----
// Purpose: Peripheral logic that drives flush and wake pulses
// Assumes: Same 100 MHz clock as its own user side
// Notes:   A flush request waits until writing has stopped
`timescale 1ns/100ps
`default_nettype none
module cmf_peripheral #(
	parameter int WAKE_LEN = cmf_pkg::WAKE_CYC // Wake pulse length in cycles
) (
	input  wire logic clk_i,
	input  wire logic resetn_i,
	input  wire logic flush_req_i,
	input  wire logic wake_req_i,
	input  wire logic writing_i,
	output logic      busy_o,
	output logic      b_space_n_o,
	output logic      b_avail_n_o,
	cmf_if.per        pins
);
	// Pulse states, Gray from idle to gap; the return from gap to idle changes both bits
	typedef enum logic [1:0] {
		PS_IDLE  = 2'b00,
		PS_LOW   = 2'b01,
		PS_GAP   = 2'b11
	} cmf_ps_t;

	cmf_ps_t                   st_q, st_d;     // Pulse state
	logic [cmf_pkg::CNT_W-1:0] cnt_q, cnt_d;   // Cycles left in phase
	logic                      pin_q, pin_d;   // Pin level driven
	logic                      spc_q, avl_q;   // Channel B flags seen

	// Pulse sequencer
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		pin_d = pin_q;
		case (st_q)
			PS_IDLE: begin
				if (wake_req_i) begin
					// Long low pulse wakes the host
					st_d  = PS_LOW;
					pin_d = 1'b0;
					cnt_d = WAKE_LEN[cmf_pkg::CNT_W-1:0] - 1'b1;
				end else if (flush_req_i && !writing_i) begin
					// Short pulse, only once writing has stopped
					st_d  = PS_LOW;
					pin_d = 1'b0;
					cnt_d = cmf_pkg::FLUSH_CYC[cmf_pkg::CNT_W-1:0] - 1'b1;
				end
			end
			PS_LOW: begin
				if (cnt_q == '0) begin
					// High gap of a flush length before the next pulse
					st_d  = PS_GAP;
					pin_d = 1'b1;
					cnt_d = cmf_pkg::FLUSH_CYC[cmf_pkg::CNT_W-1:0] - 1'b1;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			PS_GAP: begin
				if (cnt_q == '0) begin
					st_d = PS_IDLE;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			default: begin
				st_d  = PS_IDLE;
				pin_d = 1'b1;
			end
		endcase
	end

	// Register state and channel B flags
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q  <= PS_IDLE;
			cnt_q <= '0;
			pin_q <= 1'b1;
			spc_q <= 1'b1;
			avl_q <= 1'b1;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			pin_q <= pin_d;
			spc_q <= pins.b_tx_space_flag_n;
			avl_q <= pins.b_rx_avail_flag_n;
		end
	end

	assign pins.flush_wake_n = pin_q;
	assign busy_o            = (st_q != PS_IDLE);
	assign b_space_n_o       = spc_q;
	assign b_avail_n_o       = avl_q;
endmodule
`default_nettype wire

// ---- rtl/cmf_pulse_meter.sv ----
// Purpose: Synchronise the flush/wake pin and time its low pulses
// Assumes: Pin is asynchronous to clk_i
// Notes:   A change counts once second and third stages agree
`timescale 1ns/100ps
`default_nettype none
module cmf_pulse_meter (
	input  wire logic                     clk_i,
	input  wire logic                     resetn_i,
	input  wire logic                     pin_n_i,
	output logic                          fall_o,
	output logic                          rise_o,
	output logic [cmf_pkg::CNT_W-1:0]     low_cnt_o
);
	logic                      s1_q, s2_q, s3_q;   // Synchroniser chain
	logic                      lvl_q, lvl_d;       // Agreed pin level
	logic [cmf_pkg::CNT_W-1:0] cnt_q, cnt_d;       // Low time so far

	// Next level and low-time count
	always_comb begin
		lvl_d = lvl_q;
		cnt_d = cnt_q;
		if (s2_q == s3_q) begin
			lvl_d = s3_q;
		end
		if (lvl_d == 1'b0) begin
			// Saturating count while low
			if (lvl_q == 1'b1) begin
				cnt_d = '0;
			end else if (cnt_q != '1) begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	// Register chain, level and count
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1_q  <= 1'b1;
			s2_q  <= 1'b1;
			s3_q  <= 1'b1;
			lvl_q <= 1'b1;
			cnt_q <= '0;
		end else begin
			s1_q  <= pin_n_i;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
			cnt_q <= cnt_d;
		end
	end

	// Edges of the agreed level
	assign fall_o    = lvl_q & ~lvl_d;
	assign rise_o    = ~lvl_q & lvl_d;
	assign low_cnt_o = cnt_q;
endmodule
`default_nettype wire

// ---- tb/cmf_properties.sv ----
// Purpose: Timing checks on the flush/wake pin and the mode outputs
// Assumes: One clock, asynchronous active-low reset
// Notes:   Pulse lengths follow the shortened bench parameters
`timescale 1ns/100ps
`default_nettype none
module cmf_properties #(
	parameter int WAKE_LEN    = 200, // Wake pulse cycles
	parameter int WAKE_DETECT = 100  // Wake accept cycles
) (
	input wire logic		clk_i,
	input wire logic		resetn_i,
	input wire logic		flush_wake_n,
	input wire logic		b_data_oe,
	input wire logic		b_pullup_en,
	input wire logic		b_tx_space_flag_n,
	input wire logic		b_rx_avail_flag_n,
	input wire logic		send_now_o,
	input wire logic		wake_o,
	input wire logic		suspend_i,
	input wire logic		b_avail_o,
	input wire logic [3:0]	mode_a_o,
	input wire logic [1:0]	cfg_mode_a_i
);
	logic [21:0]	low_q;	// Raw low time of the pin
	logic [21:0]	low_d;	// Next low time
	logic			ok_a;	// Mode A serves the pin
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// Next low count, cleared while high
	always_comb begin
		low_d = flush_wake_n ? 22'h0 : low_q + 22'h1;
	end
	// Low count register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			low_q <= 22'h0;
		else
			low_q <= low_d;
	end
	assign ok_a = mode_a_o inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6};
	// Falling edge that must be flushed
	sequence s_fall;
		$fell(flush_wake_n) && ok_a && !suspend_i;
	endsequence
	// Quiet after a flush pulse
	sequence s_quiet;
		!send_now_o [*8];
	endsequence
	AST_FLUSH_SEEN: assert property (s_fall |-> ##[3:7] send_now_o)
		else $error("flush not signalled");
	AST_FLUSH_ONCE: assert property (send_now_o |=> s_quiet)
		else $error("flush pulse repeated");
	AST_FLUSH_MODE: assert property (send_now_o |-> ok_a && !suspend_i && !flush_wake_n)
		else $error("flush in wrong mode");
	AST_PULSE_LEN: assert property ($rose(flush_wake_n) |->
		low_q == 22'(cmf_pkg::FLUSH_CYC) || low_q == 22'(WAKE_LEN))
		else $error("pin pulse length wrong");
	AST_WAKE_TIME: assert property (wake_o |-> suspend_i && ok_a &&
		low_q >= 22'(WAKE_DETECT) && low_q <= 22'(WAKE_DETECT + 8))
		else $error("wake at wrong time");
	AST_B_SHARED: assert property (b_avail_o == (mode_a_o != cmf_pkg::CMF_SYNC_FIFO))
		else $error("channel B availability wrong");
	AST_B_HOLD: assert property (!b_avail_o && !$past(b_avail_o) |->
		$stable({b_data_oe, b_tx_space_flag_n, b_rx_avail_flag_n}))
		else $error("channel B pins moved");
	AST_RESET_DEF: assert property ($rose(resetn_i) |-> mode_a_o == 4'h0 && !b_data_oe &&
		b_pullup_en && !b_tx_space_flag_n && b_rx_avail_flag_n)
		else $error("reset state wrong");
	AST_LOAD: assert property ($rose(resetn_i) |->
		##[1:3] mode_a_o == {2'h0, cfg_mode_a_i} + {3'h0, cfg_mode_a_i[1]})
		else $error("memory mode not loaded");
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for both ends of the flush/wake link
// Assumes: Shortened wake counts, 100 MHz clock
// Notes:   Model tracks modes, reject flag and pulse counts
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int WL = 200; // Wake pulse cycles
	localparam int WD = 100; // Wake detect cycles
	logic			clk_i;
	logic			resetn_i = 1'b0;
	logic			req = 1'b0;	// Bus cycle and strobe
	logic			we = 1'b0;
	logic [3:0]		adr = 4'h0;
	logic [31:0]	wdat = 32'h0;
	logic [31:0]	rd;			// Last read data
	logic			fl_req = 1'b0;
	logic			wk_req = 1'b0;
	logic			wr = 1'b0;	// Peripheral writing
	logic			susp = 1'b0;
	logic			bact = 1'b0;
	logic [2:0]		bin = 3'h3;	// B oe, space, avail inputs
	logic [1:0]		ca = 2'h1;
	logic [1:0]		cb = 2'h1;
	logic [31:0]	dat_o;
	logic			ack, snow, wake, bav, busy, psp, pav;
	logic [3:0]		ma, mb;
	int				bad_count = 0, checks = 0, cyc_n = 0, seed = 39;
	int				ea, eb, rej, pd, ct_f, ct_w, tf = 0, tw = 0, sf = 0, sw = 0;
	int				bv[7] = '{1, 2, 4, 8, 'h40, 'h10, 0};
	int				av[5] = '{2, 1, 4, 8, 0};
	cmf_if pif ();
	wire [3:0]		bp = {pif.b_data_oe, pif.b_pullup_en, pif.b_tx_space_flag_n, pif.b_rx_avail_flag_n};
	cmf_device #(.WAKE_DETECT(WD)) cmf_device_inst (.clk_i(clk_i), .resetn_i(resetn_i),
		.wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .cfg_mode_a_i(ca), .cfg_mode_b_i(cb),
		.suspend_i(susp), .b_activity_i(bact), .b_tx_space_n_i(bin[1]), .b_rx_avail_n_i(bin[0]),
		.b_data_oe_i(bin[2]), .send_now_o(snow), .wake_o(wake), .b_avail_o(bav), .mode_a_o(ma),
		.mode_b_o(mb), .pins(pif));
	cmf_peripheral #(.WAKE_LEN(WL)) cmf_peripheral_inst (.clk_i(clk_i), .resetn_i(resetn_i),
		.flush_req_i(fl_req), .wake_req_i(wk_req), .writing_i(wr), .busy_o(busy),
		.b_space_n_o(psp), .b_avail_n_o(pav), .pins(pif));
	cmf_properties #(.WAKE_LEN(WL), .WAKE_DETECT(WD)) cmf_properties_inst (.clk_i(clk_i),
		.resetn_i(resetn_i), .flush_wake_n(pif.flush_wake_n), .b_data_oe(pif.b_data_oe),
		.b_pullup_en(pif.b_pullup_en), .b_tx_space_flag_n(pif.b_tx_space_flag_n),
		.b_rx_avail_flag_n(pif.b_rx_avail_flag_n), .send_now_o(snow), .wake_o(wake),
		.suspend_i(susp), .b_avail_o(bav), .mode_a_o(ma), .cfg_mode_a_i(ca));
	// Free-running clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Pulse totals and hang guard
	always @(posedge clk_i) begin
		sf += int'(snow === 1'b1);
		sw += int'(wake === 1'b1);
		cyc_n++;
		if (cyc_n == 20000) begin
			bad_count++;
			end_of_test;
		end
	end
	// Verdict and stop
	task automatic end_of_test;
		if (bad_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Compare and report
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	// Memory code to mode
	function automatic int mp(input int c);
		return c + int'(c > 1);
	endfunction
	// Modes that serve the pin
	function automatic int ok(input int m);
		return int'(m inside {1, 2, 3, 5, 6});
	endfunction
	// Classic single bus cycle
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		req <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dat_o;
		req <= 1'b0;
	endtask
	// Status against model
	task automatic st;
		wb(1'b0, 4'h4, 32'h0);
		chk(rd & 32'hBFF, {20'h0, 2'h2, rej[0], (ea != 2), eb[3:0], ea[3:0]});
		chk({24'h0, mb, ma}, {24'h0, eb[3:0], ea[3:0]});
	endtask
	// Bit-mode command and model update
	task automatic cmd(input int ch, input int v);
		int m;
		m = -1;
		wb(1'b1, 4'h0, 32'(ch * 256 + v));
		case (v)
			0: m = mp(ch ? cb : ca);
			1: m = 5;
			2: m = 7;
			4: m = 6;
			8: m = 8;
			'h40: m = (!ch && ca == 1 && cb == 1 && ea == 1) ? 2 : -1;
			default: m = -1;
		endcase
		rej = int'(m < 0 || (ch == 1 && ea == 2));
		if (!rej && ch)
			eb = m;
		if (!rej && !ch)
			ea = m;
		st;
	endtask
	// Flush or wake pulse, optionally while writing
	task automatic puls(input logic w, input logic hw);
		@(posedge clk_i);
		wr <= hw;
		fl_req <= !w;
		wk_req <= w;
		if (hw) begin
			repeat (8) @(posedge clk_i);
			chk({31'h0, pif.flush_wake_n}, 32'h1);
			wr <= 1'b0;
		end
		@(posedge clk_i);
		fl_req <= 1'b0;
		wk_req <= 1'b0;
		tf += ok(ea) && !susp;
		ct_f += ok(ea) && !susp;
		tw += w && susp && !pd && ok(ea);
		ct_w += w && susp && !pd && ok(ea);
		repeat (3) @(posedge clk_i);
		while (busy === 1'b1) @(posedge clk_i);
		repeat (6) @(posedge clk_i);
		chk(sf, tf);
		chk(sw, tw);
	endtask
	// Reset with memory codes
	task automatic rst(input logic [1:0] a, input logic [1:0] b);
		resetn_i <= 1'b0;
		ca <= a;
		cb <= b;
		bact <= 1'b0;
		repeat (12) @(posedge clk_i);
		chk({28'h0, ma}, 32'h0);
		chk({28'h0, bp}, 32'h5);
		resetn_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		ea = mp(a);
		eb = mp(b);
		{rej, pd, ct_f, ct_w} = '0;
		st;
	endtask
	// Main sequence
	initial begin
		rst(2'h1, 2'h1);
		chk({28'h0, bp}, 32'h5);
		puls(1'b0, 1'b1);
		puls(1'b0, 1'b0);
		foreach (bv[i]) cmd(1, bv[i]);
		foreach (av[i]) begin
			cmd(0, av[i]);
			puls(1'b0, 1'b0);
		end
		bact <= 1'b1;
		bin <= 3'($random(seed));
		repeat (4) @(posedge clk_i);
		chk({29'h0, bp[3], bp[1:0]}, {29'h0, bin});
		chk({30'h0, psp, pav}, {30'h0, bin[1:0]});
		// Software turns channel B data lines to inputs first
		bin <= {1'b0, bin[1:0]};
		repeat (4) @(posedge clk_i);
		chk({31'h0, bp[3]}, 32'h0);
		cmd(0, 'h40);
		cmd(1, 1);
		bin <= ~bin;
		repeat (4) @(posedge clk_i);
		chk({29'h0, bp[3], bp[1:0]}, {29'h0, ~bin});
		puls(1'b0, 1'b0);
		susp <= 1'b1;
		wb(1'b1, 4'h8, 32'h1);
		pd = 1;
		wb(1'b0, 4'h8, 32'h0);
		chk(rd, 32'h1);
		puls(1'b1, 1'b0);
		wb(1'b1, 4'h8, 32'h0);
		pd = 0;
		puls(1'b1, 1'b0);
		puls(1'b0, 1'b0);
		susp <= 1'b0;
		wb(1'b0, 4'hC, 32'h0);
		chk(rd, {ct_w[15:0], ct_f[15:0]});
		wb(1'b1, 4'hC, 32'h0);
		wb(1'b0, 4'hC, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, 4'h2, $random(seed));
		wb(1'b0, 4'h2, 32'h0);
		chk(rd, 32'h0);
		rst(2'h1, 2'h0);
		cmd(0, 'h40);
		// CPU-style FIFO on A serves the pin, fast serial does not
		rst(2'h2, 2'h3);
		puls(1'b0, 1'b0);
		cmd(0, 'h40);
		rst(2'h3, 2'h2);
		puls(1'b0, 1'b0);
		end_of_test;
	end
endmodule
`default_nettype wire
